// [logic/rlfd_defs.svh]
// Purpose: constants for the resettable low-frequency divider core
// Assumes: one clock domain, master tick supplied as an input strobe
// Notes:   counts are in master ticks, not system clocks
`ifndef RLFD_DEFS_SVH
`define RLFD_DEFS_SVH

// ----------------------------------------
// divider geometry
// ----------------------------------------
`define RLFD_PRESCALE          1024
`define RLFD_PRESCALE_W        10
`define RLFD_CODE_W            4
`define RLFD_CHAIN_W           32
`define RLFD_LOG2_STEP         3

// ----------------------------------------
// start-up and filtering
// ----------------------------------------
`define RLFD_STARTUP_TICKS     500
`define RLFD_STARTUP_W         9
`define RLFD_FILTER_TICKS      4
`define RLFD_FILTER_W          3

`endif

// [logic/rlfd_pkg.sv]
// Purpose: types for the resettable low-frequency divider core
// Assumes: constants live in rlfd_defs.svh
// Notes:   one-hot state codes written out
package rlfd_pkg;
    typedef enum logic [2:0] {
        RLFD_STARTUP = 3'h1,
        RLFD_FIRST   = 3'h2,
        RLFD_RUN     = 3'h4
    } rlfd_state_type;
endpackage

// [logic/rlfd_core.sv]
// Purpose: digital core of a resettable low-frequency oscillator
// Assumes: master_tick is a one-clock strobe per master oscillator period
// Notes:   rst_n stands for power-on clear; hold_pin synchronous to clock
//
// Operation
// - master ticks pass a fixed divide-by-1024 before the programmable divider.
// - programmable divider offers 1, 8, 64, 512, 4096, 2^15, 2^18, 2^21.
// - ratio_code is a 4-bit digitised pin ratio, setting factor and inversion.
// - codes 0-7 give 8^code; codes 8-15 give 8^(15-code), inverted.
// - invert_select is the top bit of active_code, the filtered ratio_code.
// - latch updates each master period; hold pin resets or keeps it reset.
// - invert 0: hold active high, forces output low; resume on timing.
// - invert 1: hold active low, forces output high; resume on timing.
// - hold never stops or re-phases oscillator or divider chain.
// - code is sampled continually, new code applied within one output cycle.
// - ratio change glitch-free, no phase below one master period.
// - new code passes a stability filter before use.
// - after power-on clear, output low for 500 master periods.
// - valid code needed first; start-up extends while code unsettled.
// - invert 0: oscillation starts after start-up unless held.
// - invert 1: high after start-up, falls after one period unless held.
`timescale 1ns/100ps
`include "rlfd_defs.svh"

module rlfd_core (
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    input  wire logic                     master_tick,
    input  wire logic [`RLFD_CODE_W-1:0]  ratio_code,
    input  wire logic                     hold_pin,
    input  wire logic                     code_valid,
    output logic                          osc_out,
    output logic [`RLFD_CODE_W-1:0]       active_code,
    output logic                          started
);
    // ----------------------------------------
    // state and storage
    // ----------------------------------------
    rlfd_pkg::rlfd_state_type     state;
    rlfd_pkg::rlfd_state_type     next_state;
    logic [`RLFD_CHAIN_W-1:0]     chain;
    logic [`RLFD_STARTUP_W-1:0]   start_cnt;
    logic [`RLFD_CODE_W-1:0]      cand_code;
    logic [`RLFD_FILTER_W-1:0]    filt_cnt;
    logic                         latch_q;
    logic                         latch_d;
    logic [`RLFD_CHAIN_W-1:0]     phase_base;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    // one 4-bit code sets factor and polarity
    wire       invert_select = active_code[`RLFD_CODE_W-1];
    wire [2:0] exp_sel = invert_select ? ~active_code[2:0] : active_code[2:0];
    // prescale bits, then octal steps; bit index picks half period
    wire [5:0] half_bit = 6'(`RLFD_PRESCALE_W - 1) + 6'(exp_sel) * 6'(`RLFD_LOG2_STEP);
    wire [`RLFD_CHAIN_W-1:0] chain_inc = chain + `RLFD_CHAIN_W'(1);
    // count from run start so the first half period opens at once
    wire [`RLFD_CHAIN_W-1:0] rel_count = chain_inc - phase_base;
    wire       phase = ~rel_count[half_bit[4:0]];
    wire       first_due = (state == rlfd_pkg::RLFD_STARTUP)
                           && (next_state == rlfd_pkg::RLFD_FIRST);
    // hold active high / hold active low
    wire       hold_active = invert_select ? ~hold_pin : hold_pin;
    wire       code_same = (ratio_code == cand_code);
    wire       filt_done = (filt_cnt == `RLFD_FILTER_W'(`RLFD_FILTER_TICKS));
    wire       start_done = (start_cnt >= `RLFD_STARTUP_W'(`RLFD_STARTUP_TICKS));
    // follow chain phase; reset when held
    assign latch_d = hold_active ? 1'b0 : phase;

    // ----------------------------------------
    // divider chain, free running
    // ----------------------------------------
    // chain ignores hold and code
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            chain <= '0;
        end else if (master_tick) begin
            chain <= chain_inc;
        end
    end

    // ----------------------------------------
    // phase reference, fixed once per power-up
    // ----------------------------------------
    // taken only at start-up, so hold never moves it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_base <= '0;
        end else if (master_tick && first_due) begin
            phase_base <= chain_inc + `RLFD_CHAIN_W'(1);
        end
    end

    // ----------------------------------------
    // code filter
    // ----------------------------------------
    // sampled every tick while code_valid is high; stable for several ticks before use
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cand_code   <= '0;
            filt_cnt    <= '0;
            active_code <= '0;
        end else if (master_tick && code_valid) begin
            cand_code <= ratio_code;
            if (!code_same) begin
                filt_cnt <= '0;
            end else if (!filt_done) begin
                filt_cnt <= filt_cnt + `RLFD_FILTER_W'(1);
            end else begin
                active_code <= cand_code;
            end
        end
    end

    // ----------------------------------------
    // start-up sequence
    // ----------------------------------------
    always_comb begin
        case (state)
            rlfd_pkg::RLFD_STARTUP: begin
                // 500 ticks; extended until code filtered
                next_state = (start_done && filt_done) ? rlfd_pkg::RLFD_FIRST
                                                       : rlfd_pkg::RLFD_STARTUP;
            end
            rlfd_pkg::RLFD_FIRST:   next_state = rlfd_pkg::RLFD_RUN;
            rlfd_pkg::RLFD_RUN:     next_state = rlfd_pkg::RLFD_RUN;
            default:                next_state = rlfd_pkg::RLFD_STARTUP;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state     <= rlfd_pkg::RLFD_STARTUP;
            start_cnt <= '0;
        end else if (master_tick) begin
            state <= next_state;
            if (!start_done) begin
                start_cnt <= start_cnt + `RLFD_STARTUP_W'(1);
            end
        end
    end

    // ----------------------------------------
    // output latch
    // ----------------------------------------
    // latch clocked once per master period; changes only on ticks
    // so no phase is shorter than one master period
    // loads in the first state, so inverted output falls one tick later
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= 1'b0;
        end else if (master_tick) begin
            if (state != rlfd_pkg::RLFD_STARTUP) begin
                latch_q <= latch_d;
            end else begin
                latch_q <= 1'b0;
            end
        end
    end

    // low during start-up; first period high when inverted
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_out <= 1'b0;
        end else if (state == rlfd_pkg::RLFD_STARTUP) begin
            osc_out <= 1'b0;
        end else if (state == rlfd_pkg::RLFD_FIRST) begin
            osc_out <= invert_select;
        end else begin
            osc_out <= latch_q ^ invert_select;
        end
    end

    assign started = (state == rlfd_pkg::RLFD_RUN);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_startup_low: assert property (@(posedge clock) disable iff (!rst_n)
        (state == rlfd_pkg::RLFD_STARTUP) |=> !osc_out)
        else $error("output not low during start-up");
    a_no_early_run: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(started) |-> start_done && filt_done)
        else $error("run entered before start-up done");
    a_chain_free: assert property (@(posedge clock) disable iff (!rst_n)
        master_tick |=> chain == $past(chain) + `RLFD_CHAIN_W'(1))
        else $error("chain did not advance");
    a_hold_low: assert property (@(posedge clock) disable iff (!rst_n)
        started && !invert_select && hold_pin && master_tick |=> ##1 (osc_out == invert_select))
        else $error("held output not low");
    a_hold_high: assert property (@(posedge clock) disable iff (!rst_n)
        started && invert_select && !hold_pin && master_tick
        && $stable(active_code) |=> ##1 (osc_out == invert_select))
        else $error("held output not high");
    a_first_high: assert property (@(posedge clock) disable iff (!rst_n)
        (state == rlfd_pkg::RLFD_FIRST) && invert_select |=> osc_out)
        else $error("inverted start not high");
    a_code_stable: assert property (@(posedge clock) disable iff (!rst_n)
        active_code != $past(active_code) |-> $past(filt_done))
        else $error("code applied unfiltered");
    a_latch_tick: assert property (@(posedge clock) disable iff (!rst_n)
        !master_tick |=> $stable(latch_q))
        else $error("latch moved without tick");
    a_polarity: assert property (@(posedge clock) disable iff (!rst_n)
        started && master_tick && (hold_pin ^ active_code[3])
        |=> ##1 (osc_out == active_code[3]))
        else $error("held level not code msb");
    a_out_on_tick: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(osc_out) |-> $past(master_tick, 2))
        else $error("output moved off a tick");
    a_startup_len: assert property (@(posedge clock) disable iff (!rst_n)
        (state != rlfd_pkg::RLFD_STARTUP)
        |-> start_cnt == `RLFD_STARTUP_W'(`RLFD_STARTUP_TICKS))
        else $error("start-up shorter than required");
    a_first_rise: assert property (@(posedge clock) disable iff (!rst_n)
        (state == rlfd_pkg::RLFD_FIRST) && !invert_select && !hold_pin && master_tick
        |=> ##1 osc_out)
        else $error("output did not start at run entry");
    a_first_fall: assert property (@(posedge clock) disable iff (!rst_n)
        (state == rlfd_pkg::RLFD_FIRST) && invert_select && hold_pin && master_tick
        |=> ##1 !osc_out)
        else $error("inverted output did not fall after one tick");
endmodule

// [bench/rlfd_hold_model.sv]
// Purpose: external logic driving the hold input
// Assumes: bench asks for hold or release as a plain level
// Notes:   maps the request onto the active sense for the polarity
`timescale 1ns/100ps

module rlfd_hold_model (
    input  wire logic clock,
    input  wire logic want_hold,
    input  wire logic invert,
    output logic      hold_pin
);
    always @(negedge clock) begin
        hold_pin <= want_hold ^ invert;
    end
endmodule

// [bench/test_rlfd_core.sv]
// Purpose: self-checking bench for rlfd_core
// Assumes: one master tick every second clock
// Notes:   only the two fastest ratios run, the rest would take hours
`timescale 1ns/100ps
`include "rlfd_defs.svh"

module test_rlfd_core;
    logic                    clock       = 1'b0;
    logic                    rst_n       = 1'b0;
    logic                    master_tick = 1'b0;
    logic [`RLFD_CODE_W-1:0] ratio_code  = 4'h0;
    logic                    code_valid  = 1'b1;
    logic                    want_hold   = 1'b0;
    logic                    invert      = 1'b0;
    logic                    hold_pin;
    logic                    osc_out;
    logic [`RLFD_CODE_W-1:0] active_code;
    logic                    started;
    int                      n_errors    = 0;
    int                      checks_done = 0;
    int                      ticks       = 0;
    int                      cycles      = 0;

    always #4 clock = ~clock;
    always @(negedge clock) master_tick <= ~master_tick;
    always @(posedge clock) ticks <= rst_n ? ticks + int'(master_tick) : 0;
    // timeout well above the roughly 32000 cycles expected
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            report_and_stop;
        end
    end

    rlfd_hold_model PARTNER (.clock(clock), .want_hold(want_hold), .invert(invert),
        .hold_pin(hold_pin));
    rlfd_core DUT (.clock(clock), .rst_n(rst_n), .master_tick(master_tick),
        .ratio_code(ratio_code), .hold_pin(hold_pin), .code_valid(code_valid),
        .osc_out(osc_out), .active_code(active_code), .started(started));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk_vec(input string nm, input logic [3:0] e, input logic [3:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_num(input string nm, input int e, input int g);
        checks_done++;
        if (g != e) begin
            n_errors++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic wait_ticks(input int n);
        repeat (2 * n) @(negedge clock);
    endtask
    // bounded wait for the next output edge, tick stamp returned
    task automatic wait_chg(output int t);
        logic v;
        v = osc_out;
        t = -1;
        repeat (9000) begin
            @(negedge clock);
            if (osc_out !== v) begin
                t = ticks;
                return;
            end
        end
    endtask
    task automatic do_reset(input logic [3:0] code, input logic hold);
        rst_n = 1'b0;
        ratio_code = code;
        invert = code[3];
        want_hold = hold;
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_start0;
        int t1, t2, t3;
        do_reset(4'h0, 1'b0);
        wait_chg(t1);
        wait_chg(t2);
        wait_chg(t3);
        chk_num("start low", 1, int'(t1 >= 500));
        chk_num("high half", 512, t2 - t1);
        chk_num("low half", 512, t3 - t2);
        chk_vec("code", 4'h0, active_code);
        chk_vec("started", 4'h1, {3'h0, started});
        $display("test start0 done");
    endtask
    task automatic t_hold;
        int r, t4;
        wait_chg(r);
        wait_chg(r);
        wait_ticks(100);
        want_hold = 1'b1;
        wait_ticks(2);
        chk_vec("held low", 4'h0, {3'h0, osc_out});
        wait_ticks(1500);
        want_hold = 1'b0;
        wait_chg(t4);
        chk_num("rephase", 2048, t4 - r);
        $display("test hold done");
    endtask
    task automatic t_code;
        int t;
        ratio_code = 4'h1;
        wait_ticks(2);
        ratio_code = 4'hF;
        invert = 1'b1;
        wait_ticks(2);
        chk_vec("unsettled", 4'h0, active_code);
        wait_ticks(600);
        chk_vec("new code", 4'hF, active_code);
        if (osc_out !== 1'b0) begin
            wait_chg(t);
        end
        want_hold = 1'b1;
        wait_ticks(2);
        chk_vec("held high", 4'h1, {3'h0, osc_out});
        $display("test code done");
    endtask
    task automatic t_valid;
        code_valid = 1'b0;
        do_reset(4'hF, 1'b1);
        wait_ticks(700);
        chk_vec("no start", 4'h0, {3'h0, started});
        chk_vec("low wait", 4'h0, {3'h0, osc_out});
        code_valid = 1'b1;
        wait_ticks(20);
        chk_vec("start", 4'h1, {3'h0, started});
        wait_ticks(600);
        chk_vec("stay high", 4'h1, {3'h0, osc_out});
        $display("test valid done");
    endtask
    task automatic t_start1;
        int t1, t2, ta, tb;
        do_reset(4'hF, 1'b0);
        wait_chg(t1);
        wait_chg(t2);
        chk_num("quick fall", 1, t2 - t1);
        chk_vec("invert bit", 4'h1, {3'h0, active_code[3]});
        ratio_code = 4'hE;
        wait_chg(ta);
        wait_chg(tb);
        chk_vec("code E", 4'hE, active_code);
        chk_num("slow half", 4096, tb - ta);
        $display("test start1 done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        t_start0;
        t_hold;
        t_code;
        t_valid;
        t_start1;
        report_and_stop;
    end
endmodule
